// [video_test_pattern_config.sv]
// Test pattern generator: configuration registers, timing, pattern colours and auto-scroll.
`timescale 1ns/100ps
module video_test_pattern_config (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic ext_pclk,
  input wire logic ext_de,
  input wire logic ext_hs,
  input wire logic ext_vs,
  output logic vid_valid,
  input wire logic vid_ready,
  output logic vid_de,
  output logic vid_hs,
  output logic vid_vs,
  output logic [23:0] vid_rgb,
  output logic gen_active
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] control;
  logic [7:0] config_reg;
  logic [7:0] ind_addr;
  logic [7:0] ind_mem [video_test_pattern_pkg::IND_COUNT];

  wire enable = control[video_test_pattern_pkg::CTL_ENABLE_BIT];
  wire [3:0] fixed_sel = control[video_test_pattern_pkg::CTL_SEL_LSB +: 4];
  wire depth18 = config_reg[video_test_pattern_pkg::CFG_DEPTH18_BIT];
  wire ext_clk_sel = config_reg[video_test_pattern_pkg::CFG_EXT_CLK_BIT];
  wire tsel = config_reg[video_test_pattern_pkg::CFG_TSEL_BIT];
  wire invert = config_reg[video_test_pattern_pkg::CFG_INVERT_BIT];
  wire auto_scroll = config_reg[video_test_pattern_pkg::CFG_AUTO_BIT];

  wire wr_control = reg_we && reg_addr == video_test_pattern_pkg::REG_CONTROL;
  wire wr_config = reg_we && reg_addr == video_test_pattern_pkg::REG_CONFIG;
  wire wr_ind_addr = reg_we && reg_addr == video_test_pattern_pkg::REG_IND_ADDR;
  wire wr_ind_data = reg_we && reg_addr == video_test_pattern_pkg::REG_IND_DATA;
  wire ind_hit = ind_addr < 8'(video_test_pattern_pkg::IND_COUNT);
  wire [4:0] ind_idx = ind_addr[4:0];
  wire [7:0] ind_rd = ind_hit ? ind_mem[ind_idx] : 8'h00;
  wire [7:0] rd_mux = (reg_addr == video_test_pattern_pkg::REG_CONTROL) ? control :
                      (reg_addr == video_test_pattern_pkg::REG_CONFIG) ? config_reg :
                      (reg_addr == video_test_pattern_pkg::REG_IND_ADDR) ? ind_addr :
                      (reg_addr == video_test_pattern_pkg::REG_IND_DATA) ? ind_rd : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      control <= video_test_pattern_pkg::CONTROL_RESET;
      config_reg <= video_test_pattern_pkg::CONFIG_RESET;
      ind_addr <= video_test_pattern_pkg::IND_ADDR_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_control) begin
        control <= reg_wdata;
      end
      if (wr_config) begin
        config_reg <= reg_wdata & video_test_pattern_pkg::CONFIG_WRITE_MASK;
      end
      if (wr_ind_addr) begin
        ind_addr <= reg_wdata;
      end
      if (reg_re) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // Writes to indices beyond the table are dropped and such reads return zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < video_test_pattern_pkg::IND_COUNT; i++) begin
        ind_mem[i] <= video_test_pattern_pkg::IND_RESET;
      end
    end else if (wr_ind_data && ind_hit) begin
      ind_mem[ind_idx] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire [11:0] h_total = {ind_mem[video_test_pattern_pkg::IND_HTOT_HI][3:0], ind_mem[video_test_pattern_pkg::IND_HTOT_LO]};
  wire [11:0] v_total = {ind_mem[video_test_pattern_pkg::IND_VTOT_HI][3:0], ind_mem[video_test_pattern_pkg::IND_VTOT_LO]};
  wire [11:0] h_act = {ind_mem[video_test_pattern_pkg::IND_HACT_HI][3:0], ind_mem[video_test_pattern_pkg::IND_HACT_LO]};
  wire [11:0] v_act = {ind_mem[video_test_pattern_pkg::IND_VACT_HI][3:0], ind_mem[video_test_pattern_pkg::IND_VACT_LO]};
  wire [11:0] hsw = {4'h0, ind_mem[video_test_pattern_pkg::IND_HSW]};
  wire [11:0] vsw = {4'h0, ind_mem[video_test_pattern_pkg::IND_VSW]};
  wire [11:0] h_start = hsw + {4'h0, ind_mem[video_test_pattern_pkg::IND_HBP]};
  wire [11:0] v_start = vsw + {4'h0, ind_mem[video_test_pattern_pkg::IND_VBP]};
  wire h_pol = ind_mem[video_test_pattern_pkg::IND_SYNC_CFG][0];
  wire v_pol = ind_mem[video_test_pattern_pkg::IND_SYNC_CFG][1];
  wire [7:0] dwell = ind_mem[video_test_pattern_pkg::IND_DWELL];
  wire [13:0] pat_mask = {ind_mem[video_test_pattern_pkg::IND_MASK_HI][5:0], ind_mem[video_test_pattern_pkg::IND_MASK_LO]};

  // Pin synchronisers: bit 3 pixel clock, 2 data enable, 1 hsync, 0 vsync.
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic pclk_prev;
  logic [7:0] div_cnt;
  logic div_tick;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pclk_prev <= 1'b0;
      div_cnt <= 8'h00;
      div_tick <= 1'b0;
    end else begin
      pin_meta <= {ext_pclk, ext_de, ext_hs, ext_vs};
      pin_sync <= pin_meta;
      pclk_prev <= pin_sync[3];
      div_tick <= div_cnt == 8'(video_test_pattern_pkg::INT_DIV_CYCLES - 1);
      div_cnt <= (div_cnt == 8'(video_test_pattern_pkg::INT_DIV_CYCLES - 1)) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  wire ext_rise = pin_sync[3] & ~pclk_prev;
  wire pix_tick = (tsel && !ext_clk_sel) ? div_tick : ext_rise;
  logic fifo_ready;
  // The output FIFO stalls the internal timing; external timing cannot wait, so a refused pixel is lost.
  wire adv = pix_tick & enable & fifo_ready;

  logic [11:0] h_cnt;
  logic [11:0] v_cnt;
  wire h_last = h_cnt >= h_total - 12'h001;
  wire v_last = v_cnt >= v_total - 12'h001;
  wire int_de = h_cnt >= h_start && h_cnt < h_start + h_act && v_cnt >= v_start && v_cnt < v_start + v_act;
  wire cur_de = tsel ? int_de : pin_sync[2];
  wire hs_act = tsel ? (h_cnt < hsw) : (pin_sync[1] ^ h_pol);
  wire vs_act = tsel ? (v_cnt < vsw) : (pin_sync[0] ^ v_pol);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !enable || !tsel) begin
      h_cnt <= 12'h000;
      v_cnt <= 12'h000;
    end else if (adv) begin
      h_cnt <= h_last ? 12'h000 : h_cnt + 12'h001;
      if (h_last) begin
        v_cnt <= v_last ? 12'h000 : v_cnt + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic prev_de;
  logic prev_vs;
  logic [7:0] h_lvl;
  logic [7:0] v_lvl;
  logic [11:0] h_acc;
  logic [11:0] v_acc;
  wire frame_start = adv & vs_act & ~prev_vs;
  wire line_end = adv & prev_de & ~cur_de;
  wire [11:0] steps = depth18 ? video_test_pattern_pkg::STEPS_18 : video_test_pattern_pkg::STEPS_24;
  wire [11:0] h_sum = h_acc + steps;
  wire [11:0] v_sum = v_acc + steps;

  // Ramps step by a running remainder so the levels spread evenly over any active size from the step count up to 4096 less the step count.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !enable) begin
      prev_de <= 1'b0;
      prev_vs <= 1'b0;
      h_lvl <= 8'h00;
      v_lvl <= 8'h00;
      h_acc <= 12'h000;
      v_acc <= 12'h000;
    end else if (adv) begin
      prev_de <= cur_de;
      prev_vs <= vs_act;
      if (!cur_de) begin
        h_lvl <= 8'h00;
        h_acc <= 12'h000;
      end else if (h_sum >= h_act) begin
        h_lvl <= h_lvl + 8'h01;
        h_acc <= h_sum - h_act;
      end else begin
        h_acc <= h_sum;
      end
      if (frame_start) begin
        v_lvl <= 8'h00;
        v_acc <= 12'h000;
      end else if (line_end && v_sum >= v_act) begin
        v_lvl <= v_lvl + 8'h01;
        v_acc <= v_sum - v_act;
      end else if (line_end) begin
        v_acc <= v_sum;
      end
    end
  end

  function automatic logic [3:0] next_pattern(input logic [3:0] cur, input logic [13:0] mask);
    logic [3:0] p;
    logic [3:0] r;
    logic found;
    p = cur;
    r = cur;
    found = 1'b0;
    for (int k = 0; k < 14; k++) begin
      p = (p >= video_test_pattern_pkg::PAT_LAST || p == 4'h0) ? 4'h1 : p + 4'h1;
      if (!found && mask[p - 4'h1]) begin
        r = p;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  logic [3:0] active_pat;
  logic [7:0] dwell_cnt;
  wire dwell_done = {1'b0, dwell_cnt} + 9'h001 >= {1'b0, dwell};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_pat <= video_test_pattern_pkg::CONTROL_RESET[video_test_pattern_pkg::CTL_SEL_LSB +: 4];
      dwell_cnt <= 8'h00;
    end else if (!auto_scroll) begin
      active_pat <= fixed_sel;
      dwell_cnt <= 8'h00;
    end else if (frame_start) begin
      // The select field is not looked at here while scrolling.
      if (dwell_done) begin
        active_pat <= next_pattern(active_pat, pat_mask);
        dwell_cnt <= 8'h00;
      end else begin
        dwell_cnt <= dwell_cnt + 8'h01;
      end
    end
  end

  wire [7:0] hl = depth18 ? {h_lvl[5:0], 2'b00} : h_lvl;
  wire [7:0] vl = depth18 ? {v_lvl[5:0], 2'b00} : v_lvl;
  wire [23:0] custom = {ind_mem[video_test_pattern_pkg::IND_CUST_R], ind_mem[video_test_pattern_pkg::IND_CUST_G],
                        ind_mem[video_test_pattern_pkg::IND_CUST_B]};
  wire [23:0] base_rgb =
    (active_pat == video_test_pattern_pkg::PAT_WHITE) ? 24'hFFFFFF :
    (active_pat == video_test_pattern_pkg::PAT_RED) ? 24'hFF0000 :
    (active_pat == video_test_pattern_pkg::PAT_GREEN) ? 24'h00FF00 :
    (active_pat == video_test_pattern_pkg::PAT_BLUE) ? 24'h0000FF :
    (active_pat == video_test_pattern_pkg::PAT_H_GRAY) ? {hl, hl, hl} :
    (active_pat == video_test_pattern_pkg::PAT_H_RED) ? {hl, 16'h0000} :
    (active_pat == video_test_pattern_pkg::PAT_H_GREEN) ? {8'h00, hl, 8'h00} :
    (active_pat == video_test_pattern_pkg::PAT_H_BLUE) ? {16'h0000, hl} :
    (active_pat == video_test_pattern_pkg::PAT_V_GRAY) ? {vl, vl, vl} :
    (active_pat == video_test_pattern_pkg::PAT_V_RED) ? {vl, 16'h0000} :
    (active_pat == video_test_pattern_pkg::PAT_V_GREEN) ? {8'h00, vl, 8'h00} :
    (active_pat == video_test_pattern_pkg::PAT_V_BLUE) ? {16'h0000, vl} :
    (active_pat == video_test_pattern_pkg::PAT_CUSTOM) ? custom : 24'h000000;
  wire [23:0] inv_rgb = invert ? ~base_rgb : base_rgb;
  wire [23:0] out_rgb = depth18 ? (inv_rgb & video_test_pattern_pkg::DEPTH18_MASK) : inv_rgb;

  ////////////////////////////////////////////////////////////////////////////
  pixel_stream_if #(.WIDTH(video_test_pattern_pkg::PIXEL_WIDTH)) gen_stream();
  pixel_stream_if #(.WIDTH(video_test_pattern_pkg::PIXEL_WIDTH)) out_stream();

  assign gen_stream.valid = adv;
  assign gen_stream.data = {cur_de, hs_act ^ h_pol, vs_act ^ v_pol, cur_de ? out_rgb : 24'h000000};
  assign fifo_ready = gen_stream.ready;
  assign out_stream.ready = vid_ready;

  pixel_fifo #(.WIDTH(video_test_pattern_pkg::PIXEL_WIDTH), .DEPTH(video_test_pattern_pkg::FIFO_DEPTH)) out_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr(gen_stream),
    .rd(out_stream)
  );

  assign vid_valid = out_stream.valid;
  assign {vid_de, vid_hs, vid_vs, vid_rgb} = out_stream.data;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gen_active <= 1'b0;
    end else begin
      gen_active <= enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_data_write;
    reg_we && reg_addr == video_test_pattern_pkg::REG_IND_DATA && ind_hit;
  endsequence
  sequence s_data_read;
    reg_re && !reg_we && reg_addr == video_test_pattern_pkg::REG_IND_DATA;
  endsequence

  property p_config_reset;
    @(posedge ref_clk) sys_rst |=> config_reg == 8'h00 && config_reg[7:5] == 3'h0;
  endproperty
  a_config_reset: assert property (p_config_reset) else $error("config not zero after reset");

  property p_depth18_bits;
    @(posedge ref_clk) disable iff (sys_rst) (adv && depth18) |-> (gen_stream.data[17:16] == 2'b00
      && gen_stream.data[9:8] == 2'b00 && gen_stream.data[1:0] == 2'b00);
  endproperty
  a_depth18_bits: assert property (p_depth18_bits) else $error("18-bit pixel has low bits set");

  property p_white_24;
    @(posedge ref_clk) disable iff (sys_rst)
      (adv && cur_de && !depth18 && !invert && active_pat == video_test_pattern_pkg::PAT_WHITE)
      |-> gen_stream.data[23:0] == 24'hFFFFFF;
  endproperty
  a_white_24: assert property (p_white_24) else $error("24-bit white is not full scale");

  property p_invert_white;
    @(posedge ref_clk) disable iff (sys_rst)
      (adv && cur_de && invert && active_pat == video_test_pattern_pkg::PAT_WHITE) |-> gen_stream.data[23:0] == 24'h000000;
  endproperty
  a_invert_white: assert property (p_invert_white) else $error("inverted white is not black");

  property p_clock_source;
    @(posedge ref_clk) disable iff (sys_rst) (tsel && !ext_clk_sel) |-> pix_tick == div_tick;
  endproperty
  a_clock_source: assert property (p_clock_source) else $error("divided clock not used");

  property p_external_timing;
    @(posedge ref_clk) disable iff (sys_rst) !tsel |-> pix_tick == ext_rise && cur_de == pin_sync[2];
  endproperty
  a_external_timing: assert property (p_external_timing) else $error("external timing not followed");

  property p_disabled_idle;
    @(posedge ref_clk) disable iff (sys_rst) !enable |-> !gen_stream.valid ##1 !gen_stream.valid || enable;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("pixel pushed while disabled");

  property p_indirect_write;
    @(posedge ref_clk) disable iff (sys_rst) s_data_write |=> ind_mem[$past(ind_idx)] == $past(reg_wdata);
  endproperty
  a_indirect_write: assert property (p_indirect_write) else $error("indirect write lost");

  property p_indirect_read;
    @(posedge ref_clk) disable iff (sys_rst) s_data_read |=> reg_rdata == $past(ind_rd) && $stable(ind_addr);
  endproperty
  a_indirect_read: assert property (p_indirect_read) else $error("indirect read wrong");

  property p_fixed_pattern;
    @(posedge ref_clk) disable iff (sys_rst) !auto_scroll ##1 !auto_scroll |-> active_pat == $past(fixed_sel);
  endproperty
  a_fixed_pattern: assert property (p_fixed_pattern) else $error("fixed pattern not held");

  property p_dwell_hold;
    @(posedge ref_clk) disable iff (sys_rst) (auto_scroll && !frame_start) ##1 auto_scroll |-> $stable(active_pat);
  endproperty
  a_dwell_hold: assert property (p_dwell_hold) else $error("pattern moved between frames");
endmodule

// [video_test_pattern_pkg.sv]
// Constants for the video test pattern generator configuration block.
// Contract
// - With the colour-depth bit set, patterns are 18-bit, ramps have 64 steps and only the six top colour bits carry.
// - With the colour-depth bit clear, patterns are 24-bit and ramps have 256 steps.
// - Under internal timing the clock-source bit picks the external pixel clock when set, the divided clock when clear.
// - The clock-source bit has no effect while the timing source select is zero.
// - With the timing-source bit set, the generator builds its own timing from the programmed frame geometry.
// - With the timing-source bit clear, the generator follows the incoming pixel clock, data enable and syncs.
// - The invert bit makes the generator output the inverted colours of the pattern, otherwise unchanged colours.
// - With auto-scroll set, the pattern moves to the next enabled one after the frame dwell count; otherwise it stays.
// - The indirect data register carries write data to, and read data from, the selected indirect register.
// - The fixed pattern select field is ignored while auto-scroll is enabled.
// - Patterns are produced only while the control enable bit is set.
package video_test_pattern_pkg;
  localparam logic [7:0] REG_CONTROL = 8'h64;
  localparam logic [7:0] REG_CONFIG = 8'h65;
  localparam logic [7:0] REG_IND_ADDR = 8'h66;
  localparam logic [7:0] REG_IND_DATA = 8'h67;
  localparam logic [7:0] CONTROL_RESET = 8'h10;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] IND_ADDR_RESET = 8'h00;
  localparam logic [7:0] IND_DATA_RESET = 8'h00;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'h1F;
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_SEL_LSB = 4;
  localparam int CFG_DEPTH18_BIT = 4;
  localparam int CFG_EXT_CLK_BIT = 3;
  localparam int CFG_TSEL_BIT = 2;
  localparam int CFG_INVERT_BIT = 1;
  localparam int CFG_AUTO_BIT = 0;
  // Indirect register indices.
  localparam logic [4:0] IND_DWELL = 5'h00;
  localparam logic [4:0] IND_HTOT_LO = 5'h01;
  localparam logic [4:0] IND_HTOT_HI = 5'h02;
  localparam logic [4:0] IND_VTOT_LO = 5'h03;
  localparam logic [4:0] IND_VTOT_HI = 5'h04;
  localparam logic [4:0] IND_HACT_LO = 5'h05;
  localparam logic [4:0] IND_HACT_HI = 5'h06;
  localparam logic [4:0] IND_VACT_LO = 5'h07;
  localparam logic [4:0] IND_VACT_HI = 5'h08;
  localparam logic [4:0] IND_HSW = 5'h09;
  localparam logic [4:0] IND_VSW = 5'h0A;
  localparam logic [4:0] IND_HBP = 5'h0B;
  localparam logic [4:0] IND_VBP = 5'h0C;
  localparam logic [4:0] IND_SYNC_CFG = 5'h0D;
  localparam logic [4:0] IND_CUST_R = 5'h0E;
  localparam logic [4:0] IND_CUST_G = 5'h0F;
  localparam logic [4:0] IND_CUST_B = 5'h10;
  localparam logic [4:0] IND_MASK_LO = 5'h11;
  localparam logic [4:0] IND_MASK_HI = 5'h12;
  localparam int IND_COUNT = 19;
  localparam logic [7:0] IND_RESET = 8'h00;
  // Timing of the internal divided pixel clock.
  localparam int REF_CLK_PERIOD_NS = 4;
  localparam int INT_PCLK_PERIOD_NS = 16;
  localparam int INT_DIV_CYCLES = INT_PCLK_PERIOD_NS / REF_CLK_PERIOD_NS;
  localparam logic [11:0] STEPS_24 = 12'h100;
  localparam logic [11:0] STEPS_18 = 12'h040;
  localparam logic [23:0] DEPTH18_MASK = 24'hFCFCFC;
  localparam logic [3:0] PAT_WHITE = 4'h1;
  localparam logic [3:0] PAT_BLACK = 4'h2;
  localparam logic [3:0] PAT_RED = 4'h3;
  localparam logic [3:0] PAT_GREEN = 4'h4;
  localparam logic [3:0] PAT_BLUE = 4'h5;
  localparam logic [3:0] PAT_H_GRAY = 4'h6;
  localparam logic [3:0] PAT_H_RED = 4'h7;
  localparam logic [3:0] PAT_H_GREEN = 4'h8;
  localparam logic [3:0] PAT_H_BLUE = 4'h9;
  localparam logic [3:0] PAT_V_GRAY = 4'hA;
  localparam logic [3:0] PAT_V_RED = 4'hB;
  localparam logic [3:0] PAT_V_GREEN = 4'hC;
  localparam logic [3:0] PAT_CUSTOM = 4'hD;
  localparam logic [3:0] PAT_V_BLUE = 4'hE;
  localparam logic [3:0] PAT_LAST = 4'hE;
  localparam int PIXEL_WIDTH = 27;
  localparam int FIFO_DEPTH = 4;
endpackage

// [pixel_stream_if.sv]
// Valid and ready pixel stream between the generator and its output FIFO.
`timescale 1ns/100ps
interface pixel_stream_if #(parameter int WIDTH = 27);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface

// [pixel_fifo.sv]
// Shift-style FIFO whose head entry is a flip-flop, so its outputs are registered.
`timescale 1ns/100ps
module pixel_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  pixel_stream_if.sink wr,
  pixel_stream_if.source rd
);
  logic [DEPTH-1:0] valid;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] sh_v;
  logic [WIDTH-1:0] sh_d [DEPTH];
  wire pop = valid[0] & rd.ready;
  wire push = wr.valid & wr.ready;

  // Ready ignores a pop in the same cycle; this costs a cycle of throughput but keeps ready a clean flop term.
  assign wr.ready = ~valid[DEPTH-1];
  assign rd.valid = valid[0];
  assign rd.data = mem[0];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    wire prev_v;
    wire load;
    if (i == DEPTH - 1) begin : g_last
      assign sh_v[i] = pop ? 1'b0 : valid[i];
      assign sh_d[i] = mem[i];
    end else begin : g_mid
      assign sh_v[i] = pop ? valid[i+1] : valid[i];
      assign sh_d[i] = pop ? mem[i+1] : mem[i];
    end
    if (i == 0) begin : g_head
      assign prev_v = 1'b1;
    end else begin : g_tail
      assign prev_v = sh_v[i-1];
    end
    assign load = push & ~sh_v[i] & prev_v;
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        valid[i] <= 1'b0;
        mem[i] <= '0;
      end else begin
        valid[i] <= sh_v[i] | load;
        mem[i] <= load ? wr.data : sh_d[i];
      end
    end
  end
endmodule

// [video_source_model.sv]
// Behavioural parallel video source that drives the external timing pins.
`timescale 1ns/100ps
module video_source_model (
  input wire logic run,
  output logic pclk,
  output logic de,
  output logic hs,
  output logic vs
);
  int n = 0;
  // The clock stands still between runs, and data moves on the falling edge, away from the sampled rise.
  // A small start offset keeps every pin change off the reference clock's rising edges.
  initial begin
    pclk = 1'b0;
    de = 1'b0;
    hs = 1'b0;
    vs = 1'b0;
    #1;
    forever begin
      #10;
      pclk = run ? ~pclk : 1'b0;
      if (run && !pclk) begin
        n = (n + 1) % 12;
        de = (n < 8);
        hs = (n == 10);
        vs = (n == 11);
      end
    end
  end
endmodule

// [video_test_pattern_config_tb.sv]
// Self-checking testbench for the test pattern configuration block.
`timescale 1ns/100ps
module video_test_pattern_config_tb;
  logic ref_clk = 1'b0, sys_rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, vid_ready = 1'b1, src_run = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic ext_pclk, ext_de, ext_hs, ext_vs, vid_valid, vid_de, vid_hs, vid_vs, gen_active;
  logic [23:0] vid_rgb;
  int num_errors = 0, checked = 0, cycles = 0;
  // Dwell, small frame geometry, sync config, custom colour and a mask enabling only pattern one.
  logic [7:0] table_val [19] = '{8'h01, 8'h08, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01,
    8'h01, 8'h01, 8'h01, 8'h00, 8'hFF, 8'h81, 8'h03, 8'h01, 8'h00};
  video_test_pattern_config i_video_test_pattern_config (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .ext_pclk(ext_pclk), .ext_de(ext_de), .ext_hs(ext_hs), .ext_vs(ext_vs), .vid_valid(vid_valid),
    .vid_ready(vid_ready), .vid_de(vid_de), .vid_hs(vid_hs), .vid_vs(vid_vs), .vid_rgb(vid_rgb),
    .gen_active(gen_active));
  video_source_model i_video_source_model (.run(src_run), .pclk(ext_pclk), .de(ext_de), .hs(ext_hs),
    .vs(ext_vs));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    @(posedge ref_clk);
    #1 chk({17'h0, reg_rdata}, {17'h0, exp});
  endtask
  // Disabling first lets the FIFO drain, so no stale word of the old mode is mistaken for a new one.
  task automatic mode(input logic [7:0] cfg, input logic [7:0] ctl);
    wr(8'h64, 8'h00);
    repeat (12) @(posedge ref_clk);
    wr(8'h65, cfg);
    wr(8'h64, ctl);
  endtask
  task automatic pix(input logic [23:0] exp, input string name);
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      #1;
      if (vid_valid === 1'b1 && vid_de === 1'b1) break;
    end
    chk({vid_valid & vid_de, vid_rgb}, {1'b1, exp});
    $display("test %0s done", name);
  endtask
  // The first word of a frame sits at line zero, column zero, so both syncs are active and blanking shows black.
  task automatic sync_word(input string name);
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      #1;
      if (vid_valid === 1'b1 && vid_vs === 1'b1) break;
    end
    chk({vid_de, vid_rgb}, 25'h0);
    chk({23'h0, vid_valid, vid_hs}, 25'h3);
    $display("test %0s done", name);
  endtask
  task automatic idle(input string name);
    logic seen;
    seen = 1'b0;
    repeat (100) begin
      @(posedge ref_clk);
      #1 seen = seen | vid_valid;
    end
    chk({24'h0, seen}, 25'h0);
    $display("test %0s done", name);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // The run needs a few thousand cycles; this ceiling only trips on a hang.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h64, 8'h10);
    rd(8'h65, 8'h00);
    rd(8'h66, 8'h00);
    rd(8'h67, 8'h00);
    wr(8'h65, 8'hFF);
    rd(8'h65, 8'h1F);
    rd(8'h70, 8'h00);
    $display("test register reset done");
    for (int i = 0; i < 19; i++) begin
      wr(8'h66, 8'(i));
      wr(8'h67, table_val[i]);
    end
    wr(8'h66, 8'h05);
    rd(8'h67, 8'h04);
    rd(8'h66, 8'h05);
    wr(8'h66, 8'h13);
    wr(8'h67, 8'hAA);
    rd(8'h67, 8'h00);
    $display("test indirect access done");
    mode(8'h04, 8'h11);
    pix(24'hFFFFFF, "internal white");
    chk({24'h0, gen_active}, 25'h1);
    sync_word("internal syncs");
    mode(8'h04, 8'hD1);
    pix(24'hFF8103, "depth 24");
    mode(8'h14, 8'hD1);
    pix(24'hFC8000, "depth 18");
    mode(8'h06, 8'hD1);
    pix(24'h007EFC, "invert");
    mode(8'h0C, 8'hD1);
    idle("external clock stopped");
    src_run <= 1'b1;
    pix(24'hFF8103, "external clock running");
    src_run <= 1'b0;
    mode(8'h00, 8'hD1);
    idle("external timing stopped");
    src_run <= 1'b1;
    pix(24'hFF8103, "external timing running");
    src_run <= 1'b0;
    mode(8'h05, 8'hD1);
    repeat (600) @(posedge ref_clk);
    pix(24'hFFFFFF, "auto scroll");
    wr(8'h64, 8'h00);
    repeat (12) @(posedge ref_clk);
    chk({24'h0, gen_active}, 25'h0);
    idle("disabled");
    close_out();
  end
endmodule
